// ### core/eew_pkg.sv
// ****************************************************************
// ****************************************************************
package eew_pkg;

  // Timing
  localparam int unsigned CLK_HZ  = 20000000;
  localparam int unsigned TW_MS   = 10;
  localparam int unsigned TW2_MS  = 20;
  localparam int unsigned TW_CYC  = (TW_MS * CLK_HZ) / 1000;
  localparam int unsigned TW2_CYC = (TW2_MS * CLK_HZ) / 1000;

  // Synchronised pin indexes
  localparam int NSYNC  = 6;
  localparam int P_SCL  = 0;
  localparam int P_SDA  = 1;
  localparam int P_STRP = 2;
  localparam int P_MODE = 3;
  localparam int P_LOCK = 4;
  localparam int P_PROT = 5;

  // Memory layout
  localparam logic [9:0] PTR_LOC   = 10'h3ff;
  localparam int         PFLAG_BIT = 2;
  localparam logic [1:0] PROT_BLK  = 2'h3;
  localparam logic [3:0] BIT_ACK   = 4'h8;
  localparam logic [4:0] ROW_B     = 5'h10;
  localparam logic [7:0] MEM_INIT  = 8'hff;

  // Register byte addresses and fields
  localparam logic [4:0] A_CTRL   = 5'h00;
  localparam logic [4:0] A_STATUS = 5'h04;
  localparam logic [4:0] A_MADDR  = 5'h08;
  localparam logic [4:0] A_MDATA  = 5'h0c;
  localparam int         C_EN     = 0;
  localparam int         S_BUSY   = 0;
  localparam int         S_LOCK   = 1;
  localparam int         S_PHIT   = 2;
  localparam int         S_CNT    = 8;
  localparam logic [1:0] R_OKAY   = 2'h0;
  localparam logic [1:0] R_SLVERR = 2'h2;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_DEV  = 6'h02,
    ST_ADDR = 6'h04,
    ST_DATA = 6'h08,
    ST_SKIP = 6'h10,
    ST_PROG = 6'h20
  } eew_st_t;

endpackage

// ### core/eew_sync.sv
`timescale 1ns/1ps
// ****************************************************************
// Two-flop synchroniser
// ****************************************************************
module eew_sync (
  input  logic clk_sys, // System clock
  input  logic rst,     // Synchronous reset
  input  logic d,       // Asynchronous level
  output logic q        // Synchronised level
);
  logic meta_r;

  // Bus lines idle high, so reset to high avoids a false edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_r <= 1'b1;
      q      <= 1'b1;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// ### core/eew_top.sv
`timescale 1ns/1ps
module eew_top #(
  parameter logic [3:0]  DEV_TYPE  = 4'h6,                 // Value is arbitrary
  parameter int unsigned PROG_CYC  = eew_pkg::TW_CYC,      // Single row program time
  parameter int unsigned PROG2_CYC = eew_pkg::TW2_CYC      // Two row program time
) (
  input  logic        clk_sys,        // 20 MHz clock
  input  logic        rst,            // Sync reset, high
  input  logic        scl_i,          // Serial clock pin
  input  logic        sda_i,          // Serial data pin level
  output logic        sda_o,          // Data drive value
  output logic        sda_oe,         // Data drive enable
  input  logic        bank_strap,     // Bank select strap
  input  logic        mode_multi,     // High multibyte, low page
  input  logic        write_lock_pin, // High blocks writes
  input  logic        protect_en,     // Protect region enable
  input  logic [4:0]  s_axi_awaddr,   // Write address
  input  logic        s_axi_awvalid,  // Write address valid
  output logic        s_axi_awready,  // Write address ready
  input  logic [31:0] s_axi_wdata,    // Write data
  input  logic [3:0]  s_axi_wstrb,    // Byte lanes
  input  logic        s_axi_wvalid,   // Write data valid
  output logic        s_axi_wready,   // Write data ready
  output logic [1:0]  s_axi_bresp,    // Write response
  output logic        s_axi_bvalid,   // Write response valid
  input  logic        s_axi_bready,   // Write response ready
  input  logic [4:0]  s_axi_araddr,   // Read address
  input  logic        s_axi_arvalid,  // Read address valid
  output logic        s_axi_arready,  // Read address ready
  output logic [31:0] s_axi_rdata,    // Read data
  output logic [1:0]  s_axi_rresp,    // Read response
  output logic        s_axi_rvalid,   // Read valid
  input  logic        s_axi_rready    // Read ready
);
  import eew_pkg::*;

  localparam int TMR_W = $clog2(PROG2_CYC + 1);

  // ****************************************************************
  // Pin synchronisers and bus condition detection
  // ****************************************************************
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] pin_s;
  logic             scl_q;
  logic             sda_q;
  logic             en_r;
  logic             start_det;
  logic             stop_det;
  logic             scl_rise;
  logic             scl_fall;

  assign pin_raw[P_SCL]  = scl_i;
  assign pin_raw[P_SDA]  = sda_i;
  assign pin_raw[P_STRP] = bank_strap;
  assign pin_raw[P_MODE] = mode_multi;
  assign pin_raw[P_LOCK] = write_lock_pin;
  assign pin_raw[P_PROT] = protect_en;

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      eew_sync u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d       (pin_raw[g]),
        .q       (pin_s[g])
      );
    end
  endgenerate

  // Previous line levels for edge detection
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= pin_s[P_SCL];
      sda_q <= pin_s[P_SDA];
    end
  end

  // Conditions need clock high on both samples to reject clock edges
  assign start_det = en_r & pin_s[P_SCL] & scl_q & sda_q & ~pin_s[P_SDA];
  assign stop_det  = en_r & pin_s[P_SCL] & scl_q & ~sda_q & pin_s[P_SDA];
  assign scl_rise  = pin_s[P_SCL] & ~scl_q;
  assign scl_fall  = ~pin_s[P_SCL] & scl_q;

  // ****************************************************************
  // Bit engine
  // ****************************************************************
  eew_st_t    st_r;
  logic [7:0] sh_r;
  logic [3:0] bcnt_r;
  logic       ack_ph_r;
  logic       active;
  logic       byte_done;
  logic       dev_match;
  logic       ack_want;

  assign active    = (st_r != ST_IDLE) && (st_r != ST_PROG);
  assign byte_done = active & scl_fall & (bcnt_r == BIT_ACK) & ~ack_ph_r;
  assign dev_match = (sh_r[7:4] == DEV_TYPE) && (sh_r[3] == pin_s[P_STRP]);

  // Shift on rising clock, MSB first
  always_ff @(posedge clk_sys) begin
    if (rst || st_r == ST_PROG || start_det) begin
      sh_r     <= 8'h00;
      bcnt_r   <= 4'h0;
      ack_ph_r <= 1'b0;
    end else if (active && scl_rise && bcnt_r != BIT_ACK) begin
      sh_r   <= {sh_r[6:0], pin_s[P_SDA]};
      bcnt_r <= bcnt_r + 4'h1;
    end else if (byte_done) begin
      ack_ph_r <= 1'b1;
    end else if (scl_fall && ack_ph_r) begin
      ack_ph_r <= 1'b0;
      bcnt_r   <= 4'h0;
    end
  end

  // Acknowledge decision per phase
  always_comb begin
    case (st_r)
      ST_DEV:  ack_want = dev_match;
      ST_ADDR: ack_want = 1'b1;
      ST_DATA: ack_want = 1'b1;
      default: ack_want = 1'b0;
    endcase
  end

  // Drive low from the eighth fall through the ninth clock
  always_ff @(posedge clk_sys) begin
    if (rst || st_r == ST_PROG) begin
      sda_oe <= 1'b0;
    end else if (byte_done) begin
      sda_oe <= ack_want;
    end else if (scl_fall && ack_ph_r) begin
      sda_oe <= 1'b0;
    end
  end

  // Open-drain: only ever pulls low
  always_ff @(posedge clk_sys) begin
    sda_o <= 1'b0;
  end

  // ****************************************************************
  // Transfer state
  // ****************************************************************
  logic [4:0] nbyte_r;
  logic       lock_r;
  logic       prog_end;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= ST_IDLE;
    end else begin
      case (st_r)
        ST_PROG: begin
          if (prog_end) begin
            st_r <= ST_IDLE;
          end
        end
        default: begin
          if (start_det) begin
            st_r <= ST_DEV;
          end else if (stop_det) begin
            // Write with data and no lock starts programming
            // Lock seen in the stop cycle itself still counts for this command
            if (st_r == ST_DATA && nbyte_r != 5'h00 && !lock_r && !pin_s[P_LOCK]) begin
              st_r <= ST_PROG;
            end else begin
              st_r <= ST_IDLE;
            end
          end else if (byte_done && st_r == ST_DEV) begin
            // Reads are acknowledged but not served here
            st_r <= (dev_match && !sh_r[0]) ? ST_ADDR : ST_SKIP;
          end else if (byte_done && st_r == ST_ADDR) begin
            st_r <= ST_DATA;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Address and write latch
  // ****************************************************************
  logic [1:0] blk_r;
  logic [7:0] addr_r;
  logic [7:0] sa_r;
  logic       mode_m_r;
  logic [7:0] lat_r [16];
  logic [15:0] lval_r;
  logic [3:0] lidx;

  // Multibyte indexes by offset, page by the wrapping low nibble
  assign lidx = mode_m_r ? 4'(addr_r - sa_r) : addr_r[3:0];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      blk_r    <= 2'h0;
      addr_r   <= 8'h00;
      sa_r     <= 8'h00;
      mode_m_r <= 1'b0;
      nbyte_r  <= 5'h00;
      lval_r   <= 16'h0000;
      lock_r   <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        lat_r[i] <= 8'h00;
      end
    end else begin
      if (start_det && st_r != ST_PROG) begin
        lock_r <= pin_s[P_LOCK];
      end else if (active) begin
        lock_r <= lock_r | pin_s[P_LOCK];
      end
      if (byte_done && st_r == ST_DEV && dev_match) begin
        blk_r <= sh_r[2:1];
      end
      if (byte_done && st_r == ST_ADDR) begin
        addr_r   <= sh_r;
        sa_r     <= sh_r;
        mode_m_r <= pin_s[P_MODE];
        nbyte_r  <= 5'h00;
        lval_r   <= 16'h0000;
      end
      if (byte_done && st_r == ST_DATA) begin
        lat_r[lidx]  <= sh_r;
        lval_r[lidx] <= 1'b1;
        if (nbyte_r != ROW_B) begin
          nbyte_r <= nbyte_r + 5'h01;
        end
        if (mode_m_r) begin
          addr_r <= addr_r + 8'h01;
        end else begin
          addr_r <= {addr_r[7:4], addr_r[3:0] + 4'h1};
        end
      end
    end
  end

  // ****************************************************************
  // Program cycle and memory
  // ****************************************************************
  logic [7:0]       mem_r [1024];
  logic [TMR_W-1:0] tmr_r;
  logic [4:0]       pidx_r;
  logic             span_r;
  logic             span_nxt;
  logic [7:0]       last_a;
  logic [9:0]       wa;
  logic [7:0]       bound;
  logic             prot_w;
  logic             mem_we;
  logic             phit_r;
  logic [7:0]       pcnt_r;

  assign last_a   = sa_r + 8'(nbyte_r) - 8'h01;
  assign span_nxt = mode_m_r && (sa_r[7:3] != last_a[7:3]);
  assign wa       = mode_m_r ? {blk_r, sa_r + 8'(pidx_r)} : {blk_r, sa_r[7:4], pidx_r[3:0]};
  assign bound    = {mem_r[PTR_LOC][7:3], 3'b000};
  assign prot_w   = pin_s[P_PROT] && !mem_r[PTR_LOC][PFLAG_BIT] && wa[9:8] == PROT_BLK
                    && wa[7:0] >= bound;
  assign mem_we   = st_r == ST_PROG && !pidx_r[4] && lval_r[pidx_r[3:0]] && !prot_w;
  assign prog_end = span_r ? (tmr_r == TMR_W'(PROG2_CYC - 1)) : (tmr_r == TMR_W'(PROG_CYC - 1));

  // Latched bytes are committed first, then the rest of the cycle is waited out
  always_ff @(posedge clk_sys) begin
    if (rst || st_r != ST_PROG) begin
      tmr_r  <= '0;
      pidx_r <= 5'h00;
      span_r <= span_nxt;
    end else begin
      tmr_r <= tmr_r + TMR_W'(1);
      if (!pidx_r[4]) begin
        pidx_r <= pidx_r + 5'h01;
      end
    end
  end

  // Storage starts erased
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < 1024; i++) begin
        mem_r[i] <= MEM_INIT;
      end
    end else if (mem_we) begin
      mem_r[wa] <= lat_r[pidx_r[3:0]];
    end
  end

  // Protect hit flag and completed cycle count for software
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phit_r <= 1'b0;
      pcnt_r <= 8'h00;
    end else begin
      if (st_r == ST_PROG && !pidx_r[4] && lval_r[pidx_r[3:0]] && prot_w) begin
        phit_r <= 1'b1;
      end else if (stop_det && st_r == ST_DATA) begin
        phit_r <= 1'b0;
      end
      if (prog_end && st_r == ST_PROG) begin
        pcnt_r <= pcnt_r + 8'h01;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  logic [4:0]  awa_r;
  logic [31:0] wd_r;
  logic [3:0]  ws_r;
  logic        wr_fire;
  logic [9:0]  maddr_r;
  logic [31:0] rd_val;
  logic        rd_ok;
  logic        wr_ok;

  assign wr_fire = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign wr_ok   = awa_r == A_CTRL || awa_r == A_STATUS || awa_r == A_MADDR || awa_r == A_MDATA;

  // Address and data taken in either order; response after both
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= R_OKAY;
      awa_r         <= 5'h00;
      wd_r          <= 32'h0000_0000;
      ws_r          <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awa_r         <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wd_r         <= s_axi_wdata;
        ws_r         <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? R_OKAY : R_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Writable registers; read-only ones ignore writes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      en_r    <= 1'b1;
      maddr_r <= 10'h000;
    end else if (wr_fire) begin
      if (awa_r == A_CTRL && ws_r[0]) begin
        en_r <= wd_r[C_EN];
      end
      if (awa_r == A_MADDR && ws_r[0]) begin
        maddr_r[7:0] <= wd_r[7:0];
      end
      if (awa_r == A_MADDR && ws_r[1]) begin
        maddr_r[9:8] <= wd_r[9:8];
      end
    end
  end

  // Read decode
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      A_CTRL:   rd_val[C_EN] = en_r;
      A_STATUS: begin
        rd_val[S_BUSY]         = st_r == ST_PROG;
        rd_val[S_LOCK]         = lock_r;
        rd_val[S_PHIT]         = phit_r;
        rd_val[S_CNT +: 8]     = pcnt_r;
      end
      A_MADDR:  rd_val[9:0] = maddr_r;
      A_MDATA:  rd_val[7:0] = mem_r[maddr_r];
      default:  rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= R_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_ok ? R_OKAY : R_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_idle_wait;
    st_r == ST_IDLE && !start_det |=> st_r == ST_IDLE;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("left idle without start");

  property p_start;
    start_det && st_r != ST_PROG |=> st_r == ST_DEV && bcnt_r == 4'h0;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_busy_quiet;
    st_r == ST_PROG |=> !sda_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("drive while programming");

  property p_dev_ack;
    byte_done && st_r == ST_DEV && dev_match |=> sda_oe && ack_ph_r;
  endproperty
  a_dev_ack: assert property (p_dev_ack) else $error("select not acknowledged");

  property p_mismatch;
    byte_done && st_r == ST_DEV && !dev_match |=> !sda_oe && st_r == ST_SKIP;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch not released");

  property p_ack_release;
    ack_ph_r && scl_fall |=> !sda_oe && bcnt_r == 4'h0;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack not released");

  property p_prog_go;
    stop_det && st_r == ST_DATA && nbyte_r != 5'h00 |=> (st_r == ST_PROG) == !lock_r;
  endproperty
  a_prog_go: assert property (p_prog_go) else $error("wrong stop outcome");

  property p_lock;
    st_r == ST_PROG |-> !lock_r;
  endproperty
  a_lock: assert property (p_lock) else $error("locked write programmed");

  property p_page_wrap;
    byte_done && st_r == ST_DATA && !mode_m_r |=>
      addr_r[7:4] == $past(addr_r[7:4]) && addr_r[3:0] == $past(addr_r[3:0]) + 4'h1;
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("page address wrong");

  property p_protect;
    mem_we |-> !(pin_s[P_PROT] && !mem_r[PTR_LOC][PFLAG_BIT] && wa[9:8] == PROT_BLK && wa[7:0] >= bound);
  endproperty
  a_protect: assert property (p_protect) else $error("protected byte written");

  property p_tw_bound;
    st_r == ST_PROG |-> tmr_r < TMR_W'(PROG2_CYC);
  endproperty
  a_tw_bound: assert property (p_tw_bound) else $error("program cycle overran");

  c_dev_ack: cover property (byte_done && st_r == ST_DEV && dev_match);
  c_prog:    cover property (st_r == ST_DATA ##1 st_r == ST_PROG);
  c_page:    cover property (byte_done && st_r == ST_DATA && !mode_m_r && nbyte_r == 5'h02);
  c_axi_rd:  cover property (s_axi_rvalid && s_axi_rready);
endmodule

// ### tb/eew_i2c_mst.sv
`timescale 1ns/1ps
// ********************************************************
// Bus master model: four system clocks per half link clock
// ********************************************************
module eew_i2c_mst (
  input  logic clk_sys, // System clock
  input  logic sda,     // Resolved data wire
  output logic scl,     // Serial clock, idle high
  output logic sda_dn,  // High pulls data low
  output logic ack_stb, // Ack sample strobe
  output logic ack_v    // Ack seen on ninth clock
);
  // Clock stands high and data released outside frames
  initial begin
    scl = 1'b1;
    sda_dn = 1'b0;
    ack_stb = 1'b0;
    ack_v = 1'b0;
  end

  // Wait whole system clocks
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Data falls while clock high
  task automatic start();
    sda_dn <= 1'b1;
    w(4);
    scl <= 1'b0;
    w(2);
  endtask

  // Data rises while clock high, then bus free time
  task automatic stop();
    sda_dn <= 1'b1;
    w(2);
    scl <= 1'b1;
    w(4);
    sda_dn <= 1'b0;
    w(8);
  endtask

  // Data moves only in the low phase, so the rise never sees it change
  task automatic bitx(input logic b);
    sda_dn <= ~b;
    w(2);
    scl <= 1'b1;
    w(4);
    scl <= 1'b0;
    w(2);
  endtask

  // Eight bits MSB first, then release and sample the ninth clock
  task automatic wbyte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      bitx(b[i]);
    end
    sda_dn <= 1'b0;
    w(2);
    scl <= 1'b1;
    w(2);
    ack_v <= ~sda;
    ack_stb <= 1'b1;
    w(1);
    ack_stb <= 1'b0;
    w(1);
    scl <= 1'b0;
    w(2);
  endtask
endmodule

// ### tb/tb_eew_top.sv
`timescale 1ns/1ps
`define CMP(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_eew_top;
  import eew_pkg::*;
  localparam int         PC  = 400;
  localparam int         PC2 = 800;
  localparam logic [3:0] DT  = 4'h9; // Value is arbitrary

  logic        clk_sys = 1'b0, rst = 1'b1;
  logic        bank_strap = 1'b1, mode_multi = 1'b0, write_lock_pin = 1'b0, protect_en = 1'b0;
  logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         scl, sda_dn, sda_o, sda_oe, ack_stb, ack_v;
  wire         sda = ~(sda_dn | (sda_oe & ~sda_o)); // Pull-up: released reads high
  logic [33:0] exp_q[$];
  int          err_total = 0, total_checks = 0;
  logic [31:0] seed = 32'h2710, r;
  logic [7:0]  wd[4];

  eew_top #(.DEV_TYPE(DT), .PROG_CYC(PC), .PROG2_CYC(PC2)) DUT (
    .clk_sys, .rst, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe, .bank_strap, .mode_multi, .write_lock_pin,
    .protect_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  eew_i2c_mst u_mst (.clk_sys, .sda, .scl, .sda_dn, .ack_stb, .ack_v);

  // ********************************************************
  // Clock, watchdog, result checking
  // ********************************************************
  always #25 clk_sys = ~clk_sys;

  // Generous span: roughly seven times the expected run
  initial begin
    repeat (40000) @(posedge clk_sys);
    err_total++;
    stop_test();
  end

  // Oldest note is matched against each result as it appears
  always @(posedge clk_sys) begin
    if (ack_stb) chk("ack", {33'h0, ack_v});
    if (s_axi_rvalid && s_axi_rready) chk("rdata", {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) chk("bresp", {32'h0, s_axi_bresp});
  end

  task automatic chk(input string n, input logic [33:0] g);
    logic [33:0] e;
    e = exp_q.pop_front();
    `CMP(n, e, g)
  endtask

  task automatic stop_test();
    repeat (2) @(posedge clk_sys);
    if (exp_q.size() != 0) err_total++;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ********************************************************
  // Drivers
  // ********************************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] e);
    exp_q.push_back({32'h0, e});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [4:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // Memory byte seen through the window registers
  task automatic peek(input logic [9:0] ad, input logic [7:0] v);
    axi_wr(A_MADDR, {22'h0, ad}, R_OKAY);
    axi_rd(A_MDATA, {R_OKAY, 24'h0, v});
  endtask

  // Write command; n below zero sends the select byte alone (a poll)
  task automatic cmd(input logic [3:0] ty, input logic sb, input logic [1:0] b, input logic [7:0] a,
                     input int n, input logic ok);
    u_mst.start();
    exp_q.push_back({33'h0, ok});
    u_mst.wbyte({ty, sb, b, 1'b0});
    for (int i = 0; i <= n; i++) begin
      exp_q.push_back({33'h0, ok});
      u_mst.wbyte(i == 0 ? a : wd[i - 1]);
    end
    u_mst.stop();
  endtask

  // ********************************************************
  // Tests
  // ********************************************************
  initial begin
    r = xs();
    bank_strap <= r[0];
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    // Byte write at random place in either mode, busy poll, then ready
    r = xs();
    wd[0] = r[23:16];
    mode_multi <= r[24];
    cmd(DT, bank_strap, r[9:8], r[7:0], 1, 1'b1);
    cmd(DT, bank_strap, 2'h0, 8'h00, -1, 1'b0);
    repeat (PC) @(posedge clk_sys);
    cmd(DT, bank_strap, 2'h0, 8'h00, -1, 1'b1);
    peek(r[9:0], wd[0]);
    $display("test byte write done");
    // Page write from offset e of a row wraps to the row start
    mode_multi <= 1'b0;
    r = xs();
    wd[0] = r[7:0];
    wd[1] = r[15:8];
    wd[2] = r[23:16];
    cmd(DT, bank_strap, 2'h1, 8'h3e, 3, 1'b1);
    repeat (PC + 100) @(posedge clk_sys);
    peek(10'h13f, wd[1]);
    peek(10'h130, wd[2]);
    $display("test page wrap done");
    // Multibyte across two rows needs the doubled program time
    mode_multi <= 1'b1;
    wd[3] = ~wd[1];
    cmd(DT, bank_strap, 2'h2, 8'h07, 2, 1'b1);
    repeat (PC + 100) @(posedge clk_sys);
    cmd(DT, bank_strap, 2'h0, 8'h00, -1, 1'b0);
    repeat (PC) @(posedge clk_sys);
    cmd(DT, bank_strap, 2'h0, 8'h00, -1, 1'b1);
    peek(10'h208, wd[1]);
    $display("test multibyte done");
    // Locked write is answered but leaves memory and busy alone
    write_lock_pin <= 1'b1;
    wd[0] = wd[3];
    cmd(DT, bank_strap, 2'h2, 8'h08, 1, 1'b1);
    write_lock_pin <= 1'b0;
    // Lock seen, not busy, three cycles completed so far
    axi_rd(A_STATUS, {R_OKAY, (32'h3 << S_CNT) | (32'h1 << S_LOCK)});
    cmd(DT, bank_strap, 2'h0, 8'h00, -1, 1'b1);
    peek(10'h208, wd[1]);
    $display("test lock done");
    // Pointer e3 with flag clear protects from e0 up once enabled
    wd[0] = 8'he3;
    cmd(DT, bank_strap, 2'h3, 8'hff, 1, 1'b1);
    repeat (PC + 100) @(posedge clk_sys);
    protect_en <= 1'b1;
    wd[0] = 8'h5a;
    cmd(DT, bank_strap, 2'h3, 8'he0, 1, 1'b1);
    repeat (PC2) @(posedge clk_sys);
    peek(10'h3e0, MEM_INIT);
    // Blocked byte flagged; the cycle itself still ran, five in all
    axi_rd(A_STATUS, {R_OKAY, (32'h5 << S_CNT) | (32'h1 << S_PHIT)});
    $display("test protect done");
    // Foreign type or strap gets no answer for the whole transfer
    cmd(~DT, bank_strap, 2'h0, 8'h00, 0, 1'b0);
    cmd(DT, ~bank_strap, 2'h0, 8'h00, 0, 1'b0);
    // Disabled block ignores starts; unmapped write is refused
    axi_wr(A_CTRL, 32'h0, R_OKAY);
    cmd(DT, bank_strap, 2'h0, 8'h00, -1, 1'b0);
    axi_wr(A_CTRL, 32'h1, R_OKAY);
    axi_wr(5'h14, 32'h0, R_SLVERR);
    cmd(DT, bank_strap, 2'h0, 8'h00, -1, 1'b1);
    axi_rd(5'h10, {R_SLVERR, 32'h0});
    $display("test select done");
    stop_test();
  end
endmodule
